//--- core/sram_port_cfg.svh
// numeric constants of the burst sram port and its controller
`ifndef SRAM_PORT_CFG_SVH
`define SRAM_PORT_CFG_SVH
`define SRAM_ADDR_W 10
`define SRAM_UPPER_W 8
`define SRAM_DEPTH 1024
`define SRAM_LANES 4
`define SRAM_LANE_W 8
`define SRAM_WORD_W 32
`define BURST_LOW_W 2
`define BURST_CNT_ZERO 2'h0
`define BURST_CNT_STEP 2'h1
`define STRAP_INTERLEAVED 1'b1
`endif

//--- core/sram_port_pkg.sv
// types shared by the sram port, its controller and the link
`include "sram_port_cfg.svh"
package sram_port_pkg;
    typedef logic [`SRAM_WORD_W-1:0] word_t;
    typedef logic [`SRAM_LANES-1:0] lane_bits_t;
    typedef logic [`SRAM_UPPER_W-1:0] upper_t;
    typedef logic [`BURST_LOW_W-1:0] low_t;
    typedef logic [`SRAM_ADDR_W-1:0] addr_t;
    typedef logic [`SRAM_LANE_W:0] lane_t;
    typedef lane_t [`SRAM_LANES-1:0] stored_t;

    typedef enum logic [1:0] {
        cmd_deselect,
        cmd_read,
        cmd_write,
        cmd_burst
    } cmd_kind_t;

    typedef struct packed {
        logic strap_meta;
        logic strap_sync;
        logic active;
        logic write_op;
        upper_t base_upper;
        low_t base_low;
        low_t count;
        logic wr_pend;
        addr_t wr_addr;
        lane_bits_t wr_sel_n;
        word_t rd_data;
        lane_bits_t rd_parity;
        logic drive_ok;
    } dev_state_t;

    typedef struct packed {
        logic qual_n;
        logic cs1_n;
        logic cs2;
        logic cs3_n;
        logic adv;
        logic we_n;
        logic oe_n;
        addr_t addr;
        lane_bits_t sel_n;
        logic pin_read;
        logic pin_write;
        logic sel_active;
        logic burst_write;
        word_t wdata_stage;
        lane_bits_t wpar_stage;
        logic drv;
        word_t dout;
        lane_bits_t pout;
        logic rd_pend;
        logic rd_valid;
        word_t rd_data;
        lane_bits_t rd_parity;
    } ctl_state_t;
endpackage

//--- core/sram_link_if.sv
// pin bundle between the burst sram port and its controller
`timescale 1ns/10ps
interface sram_link_if;
    import sram_port_pkg::*;
    upper_t addr_upper;
    logic burst_low_addr_bit0;
    logic burst_low_addr_bit1;
    logic byte_lane_write_sel_a_n;
    logic byte_lane_write_sel_b_n;
    logic byte_lane_write_sel_c_n;
    logic byte_lane_write_sel_d_n;
    logic write_strobe_n;
    logic advance_or_load;
    logic clock_qualifier_n;
    logic chip_select_one_n;
    logic chip_select_two;
    logic chip_select_three_n;
    logic output_enable_n;
    word_t ctrl_data;
    lane_bits_t ctrl_parity;
    logic ctrl_data_oe;
    word_t mem_data;
    lane_bits_t mem_parity;
    logic mem_drive_ok;
    logic mem_data_oe;
    word_t data_io;
    lane_bits_t parity_data_io;

    // output enable acts without the clock on top of the registered permission
    assign mem_data_oe = mem_drive_ok & ~output_enable_n;
    assign data_io = mem_data_oe ? mem_data : ctrl_data;
    assign parity_data_io = mem_data_oe ? mem_parity : ctrl_parity;

    modport memory (
        input addr_upper, burst_low_addr_bit0, burst_low_addr_bit1,
        input byte_lane_write_sel_a_n, byte_lane_write_sel_b_n,
        input byte_lane_write_sel_c_n, byte_lane_write_sel_d_n,
        input write_strobe_n, advance_or_load, clock_qualifier_n,
        input chip_select_one_n, chip_select_two, chip_select_three_n,
        input output_enable_n, data_io, parity_data_io, mem_data_oe,
        output mem_data, mem_parity, mem_drive_ok
    );
    modport master (
        output addr_upper, burst_low_addr_bit0, burst_low_addr_bit1,
        output byte_lane_write_sel_a_n, byte_lane_write_sel_b_n,
        output byte_lane_write_sel_c_n, byte_lane_write_sel_d_n,
        output write_strobe_n, advance_or_load, clock_qualifier_n,
        output chip_select_one_n, chip_select_two, chip_select_three_n,
        output output_enable_n, ctrl_data, ctrl_parity, ctrl_data_oe,
        input data_io, parity_data_io, mem_data_oe
    );
endinterface

//--- core/burst_low_addr_gen.sv
// low address bits of a burst step, linear or interleaved order
`timescale 1ns/10ps
module burst_low_addr_gen
    import sram_port_pkg::*;
(
    input wire low_t start_low,
    input wire low_t count,
    input wire logic interleaved,
    output low_t low_addr
);
    always_comb begin
        // both orders stay inside the aligned group of four
        if (interleaved) begin
            low_addr = start_low ^ count; // see R18
        end else begin
            low_addr = start_low + count; // see R18
        end
    end
endmodule

//--- core/flowthrough_burst_sram_port.sv
// flow-through burst sram: pin capture, burst counter, byte writes, array
// Notes on behaviour
// R1: address captured at edge selects one location
// R2: two low address bits seed burst counter
// R3: byte selects sampled, qualify lanes with write
// R4: write strobe sampled only on qualified edges
// R5: controller drives strobe low to start write
// R6: advance high on qualified edge steps counter
// R7: advance low on qualified edge loads address
// R8: controller loads fresh address after a deselect
// R9: edges ignored while clock qualifier is high
// R10: selected only for one low, two high, three low
// R11: output enable gates drivers without the clock
// R12: output enable high means data pins are inputs
// R13: drivers off during write data and deselect
// R14: drivers off first cycle after leaving deselect
// R15: unqualified edge holds state, does not deselect
// R16: strap low linear, high or open interleaved
// R17: read data follows address of previous edge
// R18: counter wraps in group of four, upper kept
// R19: only selected byte lanes written, others kept
`timescale 1ns/10ps
module flowthrough_burst_sram_port
    import sram_port_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic burst_order_strap,
    output logic device_selected,
    sram_link_if.memory link
);
    dev_state_t st_reg;
    dev_state_t st_next;

    // stored words: four lanes of eight data bits and a parity bit
    stored_t mem [0:`SRAM_DEPTH-1];

    // pin decode of the current edge
    logic qualified;
    logic cs_one_ok;
    logic cs_two_ok;
    logic cs_three_ok;
    logic selected;
    logic load_edge;
    logic advance_edge;
    logic write_strobe_on;
    lane_bits_t lane_sel_n;

    // operation that the current edge leaves behind
    logic next_active;
    logic next_write;
    logic read_capture;
    logic write_capture;
    logic emerging;

    // address of this edge, freshly loaded or stepped
    low_t adv_count;
    low_t burst_low;
    low_t load_low;
    addr_t load_addr;
    addr_t step_addr;
    addr_t cur_addr;

    // data pins split into stored lanes
    stored_t in_word;
    stored_t rd_word;
    logic fwd_match;
    lane_bits_t fwd_lane;
    word_t rd_word_data;
    lane_bits_t rd_word_par;

    // array write port, one qualified edge behind its address
    logic mem_we;
    addr_t mem_waddr;
    lane_bits_t mem_wsel_n;
    stored_t mem_wdata;

    // synchronous pins count only on a qualified edge
    assign qualified = ~link.clock_qualifier_n; // see R9

    assign cs_one_ok = ~link.chip_select_one_n;
    assign cs_two_ok = link.chip_select_two;
    assign cs_three_ok = ~link.chip_select_three_n;
    assign selected = cs_one_ok & cs_two_ok & cs_three_ok; // see R10

    assign load_edge = qualified & ~link.advance_or_load; // see R7
    assign advance_edge = qualified & link.advance_or_load; // see R6
    assign write_strobe_on = ~link.write_strobe_n; // see R4

    assign lane_sel_n = {link.byte_lane_write_sel_d_n, link.byte_lane_write_sel_c_n,
                         link.byte_lane_write_sel_b_n, link.byte_lane_write_sel_a_n}; // see R3

    // strobe and chip selects count only on a load; an advance keeps the operation
    assign next_active = load_edge ? selected : st_reg.active;
    assign next_write = load_edge ? write_strobe_on : st_reg.write_op;
    assign read_capture = qualified & next_active & ~next_write;
    assign write_capture = qualified & next_active & next_write;
    assign emerging = ~st_reg.active;

    assign load_low = {link.burst_low_addr_bit1, link.burst_low_addr_bit0}; // see R2
    assign load_addr = {link.addr_upper, load_low}; // see R1

    // burst slot that an advance moves to
    assign adv_count = low_t'(st_reg.count + `BURST_CNT_STEP);
    assign step_addr = {st_reg.base_upper, burst_low}; // see R18

    burst_low_addr_gen u_burst_low (
        .start_low(st_reg.base_low),
        .count(adv_count),
        .interleaved(st_reg.strap_sync),
        .low_addr(burst_low)
    );

    // an unqualified edge keeps the address of the last captured access
    always_comb begin
        if (load_edge) begin
            cur_addr = load_addr; // see R1
        end else if (advance_edge) begin
            cur_addr = step_addr; // see R18
        end else begin
            cur_addr = st_reg.wr_addr;
        end
    end

    // each lane is eight data bits with its parity bit on top
    always_comb begin
        for (int i = 0; i < `SRAM_LANES; i++) begin
            in_word[i] = {link.parity_data_io[i], link.data_io[i*`SRAM_LANE_W +: `SRAM_LANE_W]};
        end
    end

    // a write landing on the location read this edge is forwarded lane by lane
    assign fwd_match = st_reg.wr_pend & (st_reg.wr_addr == cur_addr);
    always_comb begin
        for (int i = 0; i < `SRAM_LANES; i++) begin
            fwd_lane[i] = fwd_match & ~st_reg.wr_sel_n[i];
            rd_word[i] = fwd_lane[i] ? in_word[i] : mem[cur_addr][i];
            rd_word_data[i*`SRAM_LANE_W +: `SRAM_LANE_W] = rd_word[i][`SRAM_LANE_W-1:0]; // see R17
            rd_word_par[i] = rd_word[i][`SRAM_LANE_W];
        end
    end

    // data phase of the write captured at the previous qualified edge
    assign mem_we = qualified & st_reg.wr_pend; // see R12
    assign mem_waddr = st_reg.wr_addr;
    assign mem_wsel_n = st_reg.wr_sel_n;
    assign mem_wdata = in_word;

    always_comb begin
        st_next = st_reg;
        // strap is static but comes from a pin, so it is synchronised
        st_next.strap_meta = burst_order_strap; // see R16
        st_next.strap_sync = st_reg.strap_meta;

        // a load takes a new base; an advance moves only the counter
        if (load_edge) begin
            st_next.base_upper = link.addr_upper; // see R1
            st_next.base_low = load_low; // see R2
            st_next.count = `BURST_CNT_ZERO;
        end else if (advance_edge) begin
            st_next.count = adv_count; // see R6
        end

        // an unqualified edge leaves every field but the two strap flops as it was
        if (qualified) begin // see R15
            st_next.active = next_active; // see R7
            st_next.write_op = next_write; // see R4
            st_next.wr_pend = write_capture; // see R3
            st_next.wr_addr = cur_addr;
            st_next.wr_sel_n = lane_sel_n; // see R3
            // drivers only for a read that does not follow a deselected cycle
            st_next.drive_ok = read_capture & ~emerging; // see R13, R14
            if (read_capture) begin
                st_next.rd_data = rd_word_data; // see R17
                st_next.rd_parity = rd_word_par;
            end
        end
    end

    // the strap flops reset to interleaved, the order of an open pin
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '0;
            st_reg.strap_meta <= `STRAP_INTERLEAVED;
            st_reg.strap_sync <= `STRAP_INTERLEAVED;
        end else begin
            st_reg <= st_next;
        end
    end

    // the array holds no reset; only lanes with a low select are written
    always_ff @(posedge mclk) begin
        if (mem_we) begin
            for (int i = 0; i < `SRAM_LANES; i++) begin
                if (!mem_wsel_n[i]) begin
                    mem[mem_waddr][i] <= mem_wdata[i]; // see R19
                end
            end
        end
    end

    // read data and drive permission stand until the next qualified edge
    assign link.mem_data = st_reg.rd_data;
    assign link.mem_parity = st_reg.rd_parity;
    // combined with output enable inside the link, outside the clock
    assign link.mem_drive_ok = st_reg.drive_ok; // see R11
    assign device_selected = st_reg.active;
endmodule

//--- core/sram_port_master.sv
// controller end that drives the burst sram pins from a command port
`timescale 1ns/10ps
module sram_port_master
    import sram_port_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire cmd_kind_t cmd_kind,
    input wire logic cmd_hold,
    input wire addr_t cmd_addr,
    input wire word_t cmd_wdata,
    input wire lane_bits_t cmd_wparity,
    input wire lane_bits_t cmd_lane_sel_n,
    input wire logic cmd_out_enable_n,
    output logic rd_valid,
    output word_t rd_data,
    output lane_bits_t rd_parity,
    sram_link_if.master link
);
    ctl_state_t st_reg;
    ctl_state_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.rd_valid = st_reg.rd_pend;
        if (st_reg.rd_pend) begin
            st_next.rd_data = link.data_io;
            st_next.rd_parity = link.parity_data_io;
        end
        // track what the memory takes on an edge where the pins were qualified
        if (!st_reg.qual_n) begin
            st_next.rd_pend = st_reg.pin_read;
            st_next.drv = st_reg.pin_write;
            st_next.dout = st_reg.wdata_stage;
            st_next.pout = st_reg.wpar_stage;
        end else begin
            st_next.rd_pend = 1'b0;
        end
        st_next.oe_n = cmd_out_enable_n;
        if (cmd_hold) begin
            st_next.qual_n = 1'b1; // see R15
        end else begin
            st_next.qual_n = 1'b0; // see R9
            st_next.sel_n = cmd_lane_sel_n; // see R3
            st_next.wdata_stage = cmd_wdata;
            st_next.wpar_stage = cmd_wparity;
            st_next.cs1_n = 1'b0;
            st_next.cs2 = 1'b1;
            st_next.cs3_n = 1'b0;
            st_next.adv = 1'b0;
            st_next.we_n = 1'b1;
            st_next.addr = cmd_addr; // see R1
            unique case (cmd_kind)
                cmd_read: begin
                    st_next.sel_active = 1'b1;
                    st_next.burst_write = 1'b0;
                end
                cmd_write: begin
                    st_next.we_n = 1'b0; // see R5
                    st_next.sel_active = 1'b1;
                    st_next.burst_write = 1'b1;
                end
                cmd_burst: begin
                    st_next.adv = st_reg.sel_active; // see R8
                    st_next.cs1_n = ~st_reg.sel_active;
                    st_next.addr = st_reg.addr;
                end
                cmd_deselect: begin
                    st_next.cs1_n = 1'b1;
                    st_next.sel_active = 1'b0;
                end
            endcase
            st_next.pin_read = st_next.sel_active & ~st_next.burst_write;
            st_next.pin_write = st_next.sel_active & st_next.burst_write;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '0;
            st_reg.cs1_n <= 1'b1;
            st_reg.we_n <= 1'b1;
            st_reg.oe_n <= 1'b1;
            st_reg.sel_n <= '1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign link.addr_upper = st_reg.addr[`SRAM_ADDR_W-1:`BURST_LOW_W];
    assign link.burst_low_addr_bit1 = st_reg.addr[1];
    assign link.burst_low_addr_bit0 = st_reg.addr[0];
    assign link.byte_lane_write_sel_a_n = st_reg.sel_n[0];
    assign link.byte_lane_write_sel_b_n = st_reg.sel_n[1];
    assign link.byte_lane_write_sel_c_n = st_reg.sel_n[2];
    assign link.byte_lane_write_sel_d_n = st_reg.sel_n[3];
    assign link.write_strobe_n = st_reg.we_n;
    assign link.advance_or_load = st_reg.adv;
    assign link.clock_qualifier_n = st_reg.qual_n;
    assign link.chip_select_one_n = st_reg.cs1_n;
    assign link.chip_select_two = st_reg.cs2;
    assign link.chip_select_three_n = st_reg.cs3_n;
    assign link.output_enable_n = st_reg.oe_n;
    assign link.ctrl_data = st_reg.dout;
    assign link.ctrl_parity = st_reg.pout;
    assign link.ctrl_data_oe = st_reg.drv;
    assign rd_valid = st_reg.rd_valid;
    assign rd_data = st_reg.rd_data;
    assign rd_parity = st_reg.rd_parity;
endmodule

//--- testbench/sram_link_sva.sv
// concurrent checks on the pin link between controller and burst sram
`timescale 1ns/10ps
module sram_link_sva
    import sram_port_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clock_qualifier_n,
    input wire logic advance_or_load,
    input wire logic chip_select_one_n,
    input wire logic chip_select_two,
    input wire logic chip_select_three_n,
    input wire logic write_strobe_n,
    input wire logic output_enable_n,
    input wire logic mem_drive_ok,
    input wire logic mem_data_oe,
    input wire logic ctrl_data_oe,
    input wire word_t mem_data
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    logic sel_pins;
    assign sel_pins = !chip_select_one_n && chip_select_two && !chip_select_three_n;
    sequence s_desel;
        !clock_qualifier_n && !advance_or_load && !sel_pins;
    endsequence
    sequence s_rd;
        !clock_qualifier_n && !advance_or_load && sel_pins && write_strobe_n;
    endsequence
    sequence s_wr;
        !clock_qualifier_n && !advance_or_load && sel_pins && !write_strobe_n;
    endsequence
    a_oe_high_tristate: assert property (output_enable_n |-> !mem_data_oe)
        else $error("data driven with output enable high");
    a_oe_async_gate: assert property (mem_drive_ok && !output_enable_n |-> mem_data_oe)
        else $error("drive permitted but data not driven");
    a_desel_no_drive: assert property (s_desel |=> !mem_drive_ok)
        else $error("drive permitted while deselected");
    a_emerge_no_drive: assert property (s_desel ##1 s_rd |=> !mem_drive_ok)
        else $error("drive permitted first cycle after deselect");
    a_write_phase_off: assert property (s_wr |=> !mem_drive_ok && ctrl_data_oe)
        else $error("write data phase drive wrong");
    a_read_drives: assert property (s_rd ##1 s_rd |=> mem_drive_ok)
        else $error("selected read not driven");
    a_stall_holds: assert property (clock_qualifier_n |=> $stable(mem_drive_ok) && $stable(mem_data))
        else $error("state changed on unqualified edge");
    a_no_contention: assert property (!(mem_data_oe && ctrl_data_oe))
        else $error("both ends drive data");
    a_reload_after_desel: assert property (s_desel ##1 !clock_qualifier_n |-> !advance_or_load)
        else $error("advance right after deselect");
endmodule

//--- testbench/flowthrough_burst_sram_port_tb.sv
// self-checking bench: controller and burst sram joined over the pin link
`timescale 1ns/10ps
module flowthrough_burst_sram_port_tb;
    import sram_port_pkg::*;
    logic mclk, reset_n, strap, rd_valid, dev_sel, hold, oe_n;
    cmd_kind_t kind;
    addr_t addr;
    word_t wdata, rd_data;
    lane_bits_t wpar, sel_n, rd_parity;
    int err_count, tests_run, cycles;
    word_t rq[$];
    lane_bits_t pq[$];
    sram_link_if link();
    sram_port_master sram_port_master_i(.mclk(mclk), .reset_n(reset_n), .cmd_kind(kind), .cmd_hold(hold),
        .cmd_addr(addr), .cmd_wdata(wdata), .cmd_wparity(wpar), .cmd_lane_sel_n(sel_n),
        .cmd_out_enable_n(oe_n), .rd_valid(rd_valid), .rd_data(rd_data), .rd_parity(rd_parity), .link(link));
    flowthrough_burst_sram_port flowthrough_burst_sram_port_i(.mclk(mclk), .reset_n(reset_n),
        .burst_order_strap(strap), .device_selected(dev_sel), .link(link));
    sram_link_sva sram_link_sva_i(.mclk(mclk), .reset_n(reset_n), .clock_qualifier_n(link.clock_qualifier_n),
        .advance_or_load(link.advance_or_load), .chip_select_one_n(link.chip_select_one_n),
        .chip_select_two(link.chip_select_two), .chip_select_three_n(link.chip_select_three_n),
        .write_strobe_n(link.write_strobe_n), .output_enable_n(link.output_enable_n),
        .mem_drive_ok(link.mem_drive_ok), .mem_data_oe(link.mem_data_oe),
        .ctrl_data_oe(link.ctrl_data_oe), .mem_data(link.mem_data));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // read results are collected mid-cycle, away from the launching edge
    always @(negedge mclk) begin
        if (rd_valid === 1'b1) begin
            rq.push_back(rd_data);
            pq.push_back(rd_parity);
        end
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic cmp_w(string what, word_t exp, word_t got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_b(string what, logic exp, logic got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic cmd(cmd_kind_t k, addr_t a, word_t d, lane_bits_t s, logic h = 1'b0);
        @(posedge mclk);
        #1;
        kind = k;
        addr = a;
        wdata = d;
        sel_n = s;
        hold = h;
    endtask

    // idle keeps the device selected: a write that enables no lane
    task automatic idle();
        cmd(cmd_write, 10'h3ff, 32'h0, 4'hf);
    endtask

    task automatic wait_q();
        for (int i = 0; i < 20 && rq.size() == 0; i++)
            @(negedge mclk);
    endtask

    task automatic get_rd(word_t exp, lane_bits_t ep);
        wait_q();
        if (rq.size() == 0) begin
            err_count++;
            $display("mismatch rd_valid expected 1 seen 0");
        end else begin
            cmp_w("rd_data", exp, rq.pop_front());
            cmp_w("rd_parity", word_t'(ep), word_t'(pq.pop_front()));
        end
    endtask

    task automatic drop();
        wait_q();
        if (rq.size() > 0) begin
            void'(rq.pop_front());
            void'(pq.pop_front());
        end
    endtask

    initial begin
        reset_n = 1'b0;
        strap = 1'b0;
        hold = 1'b0;
        oe_n = 1'b0;
        kind = cmd_deselect;
        addr = 10'h0;
        wdata = 32'h0;
        wpar = 4'h0;
        sel_n = 4'hf;
        repeat (3) @(posedge mclk);
        #1;
        reset_n = 1'b1;
        cmp_b("device_selected", 1'b0, dev_sel);
        cmp_b("rd_valid", 1'b0, rd_valid);
        $display("test reset done");
        cmd(cmd_write, 10'h010, 32'h11223344, 4'h0);
        cmd(cmd_write, 10'h010, 32'haabbccdd, 4'ha);
        wpar = 4'hf;
        cmd(cmd_read, 10'h010, 32'h0, 4'hf);
        wpar = 4'h0;
        idle();
        get_rd(32'h11bb33dd, 4'h5);
        $display("test byte lanes done");
        for (int i = 0; i < 4; i++)
            cmd(cmd_write, addr_t'(10'h020 + i), word_t'(32'h100 + i), 4'h0);
        for (int m = 0; m < 2; m++) begin
            idle();
            strap = m[0];
            repeat (2) idle();
            cmd(cmd_read, m ? 10'h021 : 10'h022, 32'h0, 4'hf);
            repeat (3) cmd(cmd_burst, 10'h000, 32'h0, 4'hf);
            idle();
            for (int i = 0; i < 4; i++)
                get_rd(word_t'(32'h100 + (m ? (1 ^ i) : ((2 + i) & 3))), 4'h0);
        end
        $display("test bursts done");
        cmd(cmd_write, 10'h030, 32'hcafe0001, 4'h0);
        cmd(cmd_write, 10'h030, 32'hdeadbeef, 4'h0, 1'b1);
        cmd(cmd_write, 10'h030, 32'hdeadbeef, 4'h0, 1'b1);
        cmd(cmd_read, 10'h030, 32'h0, 4'hf);
        idle();
        get_rd(32'hcafe0001, 4'h0);
        $display("test stall done");
        cmd(cmd_deselect, 10'h0, 32'h0, 4'hf);
        cmd(cmd_read, 10'h010, 32'h0, 4'hf);
        cmd(cmd_read, 10'h010, 32'h0, 4'hf);
        cmp_b("device_selected", 1'b0, dev_sel);
        idle();
        cmp_b("device_selected", 1'b1, dev_sel);
        drop();
        get_rd(32'h11bb33dd, 4'h5);
        $display("test deselect done");
        cmd(cmd_read, 10'h010, 32'h0, 4'hf);
        oe_n = 1'b1;
        repeat (2) cmd(cmd_read, 10'h010, 32'h0, 4'hf);
        cmp_b("mem_drive_ok", 1'b1, link.mem_drive_ok);
        cmp_b("mem_data_oe", 1'b0, link.mem_data_oe);
        oe_n = 1'b0;
        idle();
        repeat (3) drop();
        $display("test output enable done");
        final_report();
    end
endmodule
